// File: timer_channel.sv
// one timer channel: 16-bit counter, optional split into two 8-bit halves
`include "tmr_defs.svh"
module timer_channel import tmr_pkg::*; #(
  parameter int W = `TMR_CNT_W,
  parameter bit CAN_SPLIT = 1'b0,
  parameter bit CAN_DIV = 1'b0
) (
  input wire logic sys_clk_i, // unit clock
  input wire logic rst_n_i, // async reset, active low
  input wire logic clr_i, // unit held in reset
  input wire logic start_i, // start pulse
  input wire logic stop_i, // stop pulse
  input wire mode_t mode_i, // operating mode
  input wire logic [W-1:0] period_i, // compare / reload value
  input wire logic split_i, // two 8-bit halves
  input wire logic fall_i, // valid edge is falling
  input wire logic slave_i, // restart on master event
  input wire logic trig_i, // master event
  input wire logic pos_i, // rising edge seen on input
  input wire logic neg_i, // falling edge seen on input
  output logic irq_o, // channel event, one cycle
  output logic irq_hi_o, // upper half event, one cycle
  output logic out_o, // output pin level
  output logic running_o, // channel counting
  output logic [W-1:0] capture_o // last captured count
);
  localparam int H = `TMR_HALF_W;
  typedef struct packed {
    logic [W-1:0] cnt;
    logic [H-1:0] cnt_hi;
    logic [W-1:0] cap;
    logic run;
    logic armed;
    logic out;
    logic irq;
    logic irq_hi;
  } ch_state_t;
  ch_state_t r, r_nxt;
  logic split, vedge, oedge, zero;
  mode_t eff;

  function automatic logic at_zero(input logic [W-1:0] c, input logic s);
    return s ? (c[H-1:0] == '0) : (c == '0);
  endfunction : at_zero

  function automatic logic [W-1:0] down(input logic [W-1:0] c, input logic s);
    return s ? {c[W-1:H], c[H-1:0] - 1'b1} : c - 1'b1;
  endfunction : down

  function automatic logic [W-1:0] reload(input logic [W-1:0] p, input logic s);
    return s ? {{(W-H){1'b0}}, p[H-1:0]} : p;
  endfunction : reload

  // split only on channels built for it; unsupported half modes fall back to interval
  assign split = CAN_SPLIT && split_i;
  assign eff = (split && !(mode_i inside {MODE_INTERVAL, MODE_SQUARE, MODE_EVENT, MODE_DELAY}))
    ? MODE_INTERVAL : mode_i;
  assign vedge = fall_i ? neg_i : pos_i;
  assign oedge = fall_i ? pos_i : neg_i;
  assign zero = at_zero(r.cnt, split);

  // next state of the channel
  always_comb begin
    r_nxt = r;
    r_nxt.irq = 1'b0;
    r_nxt.irq_hi = 1'b0;
    if (clr_i) begin
      r_nxt = '0;
    end else if (stop_i) begin
      r_nxt.run = 1'b0;
      r_nxt.armed = 1'b0;
    end else if (start_i || (slave_i && trig_i)) begin
      r_nxt.run = 1'b1;
      // a master event stands in for the start edge of a slave
      r_nxt.armed = !(slave_i && trig_i)
        && (eff inside {MODE_DELAY, MODE_PULSE_INT, MODE_LEVEL_WIDTH});
      r_nxt.cnt = (eff inside {MODE_PULSE_INT, MODE_LEVEL_WIDTH}) ? `TMR_CNT_RESET
        : reload(period_i, split);
      r_nxt.cnt_hi = period_i[W-1:W-H];
    end else if (r.run) begin
      case (eff)
        MODE_INTERVAL, MODE_SQUARE: begin
          if (zero) begin
            r_nxt.irq = 1'b1;
            r_nxt.cnt = reload(period_i, split);
            if (eff == MODE_SQUARE) r_nxt.out = ~r.out;
          end else begin
            r_nxt.cnt = down(r.cnt, split);
          end
        end
        MODE_EVENT, MODE_DIVIDER: begin
          // divider needs the clock pin of channel 0; elsewhere it stays idle
          if (vedge && (eff == MODE_EVENT || CAN_DIV)) begin
            if (zero) begin
              r_nxt.irq = 1'b1;
              r_nxt.cnt = reload(period_i, split);
              if (eff == MODE_DIVIDER) r_nxt.out = ~r.out;
            end else begin
              r_nxt.cnt = down(r.cnt, split);
            end
          end
        end
        MODE_DELAY: begin
          if (r.armed) begin
            if (vedge) begin
              r_nxt.armed = 1'b0;
              r_nxt.cnt = reload(period_i, split);
            end
          end else if (zero) begin
            r_nxt.irq = 1'b1;
            r_nxt.armed = 1'b1;
          end else begin
            r_nxt.cnt = down(r.cnt, split);
          end
        end
        MODE_PULSE_INT: begin
          if (r.armed) begin
            if (vedge) begin
              r_nxt.armed = 1'b0;
              r_nxt.cnt = `TMR_CNT_RESET;
            end
          end else if (vedge) begin
            r_nxt.cap = r.cnt;
            r_nxt.irq = 1'b1;
            r_nxt.cnt = `TMR_CNT_RESET;
          end else begin
            r_nxt.cnt = r.cnt + 1'b1;
          end
        end
        MODE_LEVEL_WIDTH: begin
          if (r.armed) begin
            if (vedge) begin
              r_nxt.armed = 1'b0;
              r_nxt.cnt = `TMR_CNT_RESET;
            end
          end else if (oedge) begin
            r_nxt.cap = r.cnt;
            r_nxt.irq = 1'b1;
            r_nxt.armed = 1'b1;
          end else begin
            r_nxt.cnt = r.cnt + 1'b1;
          end
        end
        default: ;
      endcase
      // upper half is always a plain interval timer
      if (split) begin
        if (r.cnt_hi == '0) begin
          r_nxt.irq_hi = 1'b1;
          r_nxt.cnt_hi = period_i[W-1:W-H];
        end else begin
          r_nxt.cnt_hi = r.cnt_hi - 1'b1;
        end
      end
    end
  end

  // state register
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else begin
      r <= r_nxt;
    end
  end

  assign irq_o = r.irq;
  assign irq_hi_o = r.irq_hi;
  assign out_o = r.out;
  assign running_o = r.run;
  assign capture_o = r.cap;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic quiet;
  assign quiet = !clr_i && !stop_i && !start_i && !(slave_i && trig_i);

  property p_interval;
    (quiet && r.run && eff == MODE_INTERVAL && zero) |=> irq_o;
  endproperty
  a_interval: assert property (p_interval) else $error("interval expiry gave no event");
  property p_square;
    (irq_o && $past(eff == MODE_SQUARE && quiet)) |-> (out_o != $past(out_o));
  endproperty
  a_square: assert property (p_square) else $error("square output did not toggle");
  property p_event;
    (irq_o && $past(eff == MODE_EVENT && quiet)) |-> $past(vedge && zero);
  endproperty
  a_event: assert property (p_event) else $error("event count fired without edge");
  property p_div_only;
    (!CAN_DIV && $past(eff == MODE_DIVIDER && quiet)) |-> $stable(out_o) && !irq_o;
  endproperty
  a_div_only: assert property (p_div_only) else $error("divider acted off channel 0");
  property p_pulse;
    (irq_o && $past(eff == MODE_PULSE_INT && quiet)) |-> capture_o == $past(r.cnt);
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse interval capture wrong");
  property p_level;
    (irq_o && $past(eff == MODE_LEVEL_WIDTH && quiet)) |-> $past(oedge) && r.armed;
  endproperty
  a_level: assert property (p_level) else $error("level width capture off edge");
  property p_delay;
    (quiet && r.run && !r.armed && eff == MODE_DELAY && zero) |=> irq_o && r.armed;
  endproperty
  a_delay: assert property (p_delay) else $error("delay expiry gave no event");
  property p_split_hi;
    irq_hi_o |-> CAN_SPLIT && $past(split);
  endproperty
  a_split_hi: assert property (p_split_hi) else $error("upper half fired unsplit");
  property p_slave;
    (slave_i && trig_i && !clr_i && !stop_i && !start_i) |=> running_o && !r.armed;
  endproperty
  a_slave: assert property (p_slave) else $error("slave missed master event");
  c_square: cover property (irq_o && out_o && eff == MODE_SQUARE);
  c_pulse: cover property (irq_o && eff == MODE_PULSE_INT && capture_o != '0);
  c_delay: cover property (irq_o && eff == MODE_DELAY);
  c_split: cover property (irq_hi_o ##1 irq_o [*1]);
endmodule : timer_channel

// File: tmr_defs.svh
// constants shared by the timer unit files
`ifndef TMR_DEFS_SVH
`define TMR_DEFS_SVH
`define TMR_CNT_W 16
`define TMR_HALF_W 8
`define TMR_NUM_CH 8
`define TMR_DIV_CH 0
`define TMR_SPLIT_CH_A 1
`define TMR_SPLIT_CH_B 3
`define TMR_LIN_CH 7
`define TMR_CNT_RESET 16'h0000
`endif

// File: tmr_pkg.sv
// types shared by the timer unit files
package tmr_pkg;
  typedef enum logic [2:0] {
    MODE_INTERVAL,
    MODE_SQUARE,
    MODE_EVENT,
    MODE_DIVIDER,
    MODE_PULSE_INT,
    MODE_LEVEL_WIDTH,
    MODE_DELAY
  } mode_t;
endpackage : tmr_pkg

// File: multi_channel_timer_unit.sv
// eight-channel timer unit: input synchronisers, control latch and channel array
`include "tmr_defs.svh"
module multi_channel_timer_unit import tmr_pkg::*; #(
  parameter int W = `TMR_CNT_W
) (
  input wire logic sys_clk_i, // 40 MHz unit clock
  input wire logic rst_n_i, // async reset, active low
  input wire logic unit_clock_supply_enable_i, // unit on
  input wire logic [`TMR_NUM_CH-1:0] ch_start_i, // start pulses
  input wire logic [`TMR_NUM_CH-1:0] ch_stop_i, // stop pulses
  input wire logic [`TMR_NUM_CH-1:0][2:0] ch_mode_i, // mode per channel
  input wire logic [`TMR_NUM_CH-1:0][W-1:0] ch_period_i, // compare value per channel
  input wire logic [`TMR_NUM_CH-1:0] ch_split_i, // split request
  input wire logic [`TMR_NUM_CH-1:0] ch_fall_i, // falling edge valid
  input wire logic [`TMR_NUM_CH-1:0] ch_slave_i, // slave of a master
  input wire logic [`TMR_NUM_CH-1:0][2:0] ch_master_sel_i, // master index
  input wire logic lin_sel_i, // channel 7 watches serial rx
  input wire logic [`TMR_NUM_CH-1:0] channel_input_pin_i, // timer input pins
  input wire logic lin_serial_channel_rx_i, // serial receive line
  output logic [`TMR_NUM_CH-1:0] channel_irq_o, // channel events
  output logic [`TMR_NUM_CH-1:0] channel_irq_hi_o, // upper half events
  output logic [`TMR_NUM_CH-1:0] channel_output_pin_o, // timer output pins
  output logic [`TMR_NUM_CH-1:0] channel_running_o, // counting status
  output logic [`TMR_NUM_CH-1:0][W-1:0] channel_capture_o // captured counts
);
  localparam int N = `TMR_NUM_CH;
  localparam logic [N-1:0] SPLIT_MASK = N'((1 << `TMR_SPLIT_CH_A) | (1 << `TMR_SPLIT_CH_B));

  typedef struct packed {
    logic [N-1:0][2:0] mode;
    logic [N-1:0][W-1:0] period;
    logic [N-1:0] split;
    logic [N-1:0] fall;
    logic [N-1:0] slave;
    logic [N-1:0][2:0] msel;
    logic lin_sel;
    logic [N:0] s1;
    logic [N:0] s2;
    logic [N:0] s3;
  } unit_state_t;
  unit_state_t r, r_nxt;
  logic clr;
  logic [N-1:0] lvl, prv, pos, neg, start_g, stop_g;

  // control is only taken while the unit has its clock supply
  assign clr = !unit_clock_supply_enable_i;
  assign start_g = ch_start_i & {N{unit_clock_supply_enable_i}};
  assign stop_g = ch_stop_i & {N{unit_clock_supply_enable_i}};

  // sync chain runs always so edges are clean when the unit is enabled
  always_comb begin
    r_nxt = r;
    r_nxt.s1 = {lin_serial_channel_rx_i, channel_input_pin_i};
    r_nxt.s2 = r.s1;
    r_nxt.s3 = r.s2;
    if (clr) begin
      r_nxt.mode = '0;
      r_nxt.period = '0;
      r_nxt.split = '0;
      r_nxt.fall = '0;
      r_nxt.slave = '0;
      r_nxt.msel = '0;
      r_nxt.lin_sel = 1'b0;
    end else begin
      r_nxt.mode = ch_mode_i;
      r_nxt.period = ch_period_i;
      r_nxt.split = ch_split_i & SPLIT_MASK;
      r_nxt.fall = ch_fall_i;
      r_nxt.slave = ch_slave_i;
      r_nxt.msel = ch_master_sel_i;
      r_nxt.lin_sel = lin_sel_i;
    end
  end

  // state register
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
      // serial line idles high; preset its stages so reset release gives no false edge
      r.s1[N] <= 1'b1;
      r.s2[N] <= 1'b1;
      r.s3[N] <= 1'b1;
    end else begin
      r <= r_nxt;
    end
  end

  // channels share only the unit enable clear and the master event; modes interact only through slave restart
  for (genvar i = 0; i < N; i++) begin : g_ch
    if (i == `TMR_LIN_CH) begin : g_lin
      assign lvl[i] = r.lin_sel ? r.s2[N] : r.s2[i];
      assign prv[i] = r.lin_sel ? r.s3[N] : r.s3[i];
    end else begin : g_pin
      assign lvl[i] = r.s2[i];
      assign prv[i] = r.s3[i];
    end
    // edge detect reads only the second and third stages
    assign pos[i] = lvl[i] & ~prv[i];
    assign neg[i] = ~lvl[i] & prv[i];

    timer_channel #(
      .W(W),
      .CAN_SPLIT((i == `TMR_SPLIT_CH_A) || (i == `TMR_SPLIT_CH_B)),
      .CAN_DIV(i == `TMR_DIV_CH)
    ) u_ch (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .clr_i(clr),
      .start_i(start_g[i]),
      .stop_i(stop_g[i]),
      .mode_i(mode_t'(r.mode[i])),
      .period_i(r.period[i]),
      .split_i(r.split[i]),
      .fall_i(r.fall[i]),
      .slave_i(r.slave[i]),
      .trig_i(channel_irq_o[r.msel[i]]),
      .pos_i(pos[i]),
      .neg_i(neg[i]),
      .irq_o(channel_irq_o[i]),
      .irq_hi_o(channel_irq_hi_o[i]),
      .out_o(channel_output_pin_o[i]),
      .running_o(channel_running_o[i]),
      .capture_o(channel_capture_o[i])
    );
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_unit_clear;
    clr |=> channel_running_o == '0 && channel_irq_o == '0 && r.period == '0;
  endproperty
  a_unit_clear: assert property (p_unit_clear) else $error("disabled unit not held in reset");
  property p_sync;
    $past(rst_n_i, 2) |-> r.s2 == $past({lin_serial_channel_rx_i, channel_input_pin_i}, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("input sync latency wrong");
  property p_lin;
    r.lin_sel |-> lvl[`TMR_LIN_CH] == $past(lin_serial_channel_rx_i, 2)
      && prv[`TMR_LIN_CH] == $past(lin_serial_channel_rx_i, 3);
  endproperty
  a_lin: assert property (p_lin) else $error("channel 7 not on serial line");
  property p_split_ch;
    (channel_irq_hi_o & ~SPLIT_MASK) == '0;
  endproperty
  a_split_ch: assert property (p_split_ch) else $error("split seen on wrong channel");
  c_lin: cover property (r.lin_sel && channel_irq_o[`TMR_LIN_CH]);
endmodule : multi_channel_timer_unit

// File: pin_source.sv
// external signal source model for the timer input pins and the serial rx line
module pin_source (
  input wire logic clk_i, // unit clock
  output logic [7:0] pin_o, // timer input pins
  output logic rx_o // serial receive line
);
  timeunit 1ns;
  timeprecision 100ps;
  // pins rest low, the serial line idles high as on a real bus
  initial begin
    pin_o = 8'h00;
    rx_o = 1'b1;
  end
  // a level is held hold+1 clocks; idx 8 is the rx line
  // keep hold >= 1 between edges, faster edges may be lost
  task automatic drive(input int idx, input logic v, input int hold);
    @(posedge clk_i);
    #2;
    if (idx == 8) rx_o = v;
    else pin_o[idx] = v;
    repeat (hold) @(posedge clk_i);
  endtask : drive
endmodule : pin_source

// File: tb_multi_channel_timer_unit.sv
// self-checking bench for the eight-channel timer unit
module tb_multi_channel_timer_unit;
  timeunit 1ns;
  timeprecision 100ps;
  import tmr_pkg::*;
  logic clk, rst_n, en, lin_sel;
  logic [7:0] start, stop, split, fall, slave, pins, irq, irqh, outp, run;
  logic rx;
  logic [7:0][2:0] mode, msel;
  logic [7:0][15:0] per, cap;
  int icnt[8], hcnt[8];
  int errors, checks_done, cycles, n, n1;
  logic o;

  pin_source src (.clk_i(clk), .pin_o(pins), .rx_o(rx));
  multi_channel_timer_unit dut (.sys_clk_i(clk), .rst_n_i(rst_n),
    .unit_clock_supply_enable_i(en), .ch_start_i(start), .ch_stop_i(stop),
    .ch_mode_i(mode), .ch_period_i(per), .ch_split_i(split), .ch_fall_i(fall),
    .ch_slave_i(slave), .ch_master_sel_i(msel), .lin_sel_i(lin_sel),
    .channel_input_pin_i(pins), .lin_serial_channel_rx_i(rx), .channel_irq_o(irq),
    .channel_irq_hi_o(irqh), .channel_output_pin_o(outp), .channel_running_o(run),
    .channel_capture_o(cap));

  // 25 ns period
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // event tally per channel; cleared by the scenarios off the edge
  always @(posedge clk) begin
    cycles++;
    for (int i = 0; i < 8; i++) begin
      if (irq[i] === 1'b1) icnt[i]++;
      if (irqh[i] === 1'b1) hcnt[i]++;
    end
    if (cycles == 6000) begin
      errors++;
      end_sim();
    end
  end

  task automatic end_sim;
    $display("checks_done=%0d errors=%0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // inputs change 2 ns after the edge, outputs are read there too
  task automatic tick;
    @(posedge clk);
    #2;
  endtask : tick

  task automatic clr;
    for (int i = 0; i < 8; i++) begin
      icnt[i] = 0;
      hcnt[i] = 0;
    end
  endtask : clr

  // config is latched a cycle late, so two edges pass before any start
  task automatic cfg(input int c, input mode_t m, input logic [15:0] p, input logic f);
    mode[c] = m;
    per[c] = p;
    fall[c] = f;
    tick();
    tick();
  endtask : cfg

  task automatic go(input logic [7:0] mask);
    start = mask;
    tick();
    start = 8'h00;
    clr();
  endtask : go

  task automatic halt;
    stop = 8'hff;
    tick();
    stop = 8'h00;
    split = 8'h00;
    slave = 8'h00;
    tick();
    clr();
  endtask : halt

  // bounded wait for the next event of one channel; n is the cycles waited
  task automatic wait_irq(input int c, input logic hi, output int cnt);
    cnt = 0;
    do begin
      tick();
      cnt++;
    end while (((hi ? irqh[c] : irq[c]) !== 1'b1) && cnt < 600);
  endtask : wait_irq

  task automatic t_interval;
    cfg(2, MODE_INTERVAL, 16'h0002, 1'b0);
    cfg(5, MODE_SQUARE, 16'h0003, 1'b0);
    go(8'h24);
    tick();
    chk(run[2], 1'b1);
    wait_irq(2, 1'b0, n);
    wait_irq(2, 1'b0, n);
    chk(16'(n), 16'h0003);
    wait_irq(5, 1'b0, n);
    o = outp[5];
    wait_irq(5, 1'b0, n);
    chk(16'(n), 16'h0004);
    // concatenation keeps the inversion to one bit before it is widened
    chk(outp[5], {15'h0000, ~o});
    halt();
  endtask : t_interval

  task automatic t_event_div;
    cfg(0, MODE_EVENT, 16'h0002, 1'b0);
    go(8'h01);
    repeat (6) begin
      src.drive(0, 1'b1, 2);
      src.drive(0, 1'b0, 2);
    end
    repeat (6) tick();
    chk(16'(icnt[0]), 16'h0002);
    halt();
    cfg(0, MODE_DIVIDER, 16'h0000, 1'b0);
    cfg(2, MODE_DIVIDER, 16'h0000, 1'b0);
    go(8'h05);
    repeat (3) begin
      src.drive(0, 1'b1, 2);
      src.drive(2, 1'b1, 2);
      src.drive(0, 1'b0, 2);
      src.drive(2, 1'b0, 2);
    end
    repeat (6) tick();
    chk(outp[0], 1'b1);
    chk(16'(icnt[0]), 16'h0003);
    chk({outp[2], 15'(icnt[2])}, 16'h0000);
    halt();
  endtask : t_event_div

  // rising edges 10 clocks apart, then a 7-clock high, then a 12-clock low on rx
  task automatic t_measure;
    cfg(4, MODE_PULSE_INT, 16'h0000, 1'b0);
    go(8'h10);
    repeat (2) begin
      src.drive(4, 1'b1, 4);
      src.drive(4, 1'b0, 4);
    end
    repeat (4) tick();
    chk(cap[4], 16'h0009);
    cfg(6, MODE_LEVEL_WIDTH, 16'h0000, 1'b0);
    go(8'h40);
    src.drive(6, 1'b1, 6);
    src.drive(6, 1'b0, 3);
    repeat (4) tick();
    chk(cap[6], 16'h0006);
    lin_sel = 1'b1;
    cfg(7, MODE_LEVEL_WIDTH, 16'h0000, 1'b1);
    go(8'h80);
    src.drive(8, 1'b0, 11);
    src.drive(8, 1'b1, 3);
    repeat (4) tick();
    chk(cap[7], 16'h000b);
    lin_sel = 1'b0;
    halt();
  endtask : t_measure

  // latency grows by exactly the change in programmed delay
  task automatic t_delay;
    cfg(5, MODE_DELAY, 16'h0004, 1'b0);
    go(8'h20);
    src.drive(5, 1'b1, 0);
    wait_irq(5, 1'b0, n1);
    src.drive(5, 1'b0, 3);
    cfg(5, MODE_DELAY, 16'h000a, 1'b0);
    src.drive(5, 1'b1, 0);
    wait_irq(5, 1'b0, n);
    chk(16'(n - n1), 16'h0006);
    src.drive(5, 1'b0, 3);
    halt();
  endtask : t_delay

  task automatic t_split;
    split = 8'h06;
    cfg(1, MODE_INTERVAL, 16'h0502, 1'b0);
    cfg(2, MODE_INTERVAL, 16'h0100, 1'b0);
    go(8'h06);
    wait_irq(1, 1'b0, n);
    wait_irq(1, 1'b0, n);
    chk(16'(n), 16'h0003);
    wait_irq(1, 1'b1, n);
    wait_irq(1, 1'b1, n);
    chk(16'(n), 16'h0006);
    wait_irq(2, 1'b0, n);
    wait_irq(2, 1'b0, n);
    chk(16'(n), 16'h0101);
    halt();
    split = 8'h02;
    cfg(1, MODE_SQUARE, 16'h0502, 1'b0);
    go(8'h02);
    wait_irq(1, 1'b0, n);
    o = outp[1];
    wait_irq(1, 1'b0, n);
    chk({15'(n), outp[1]}, {15'h0003, ~o});
    halt();
  endtask : t_split

  // a slave with a longer period never fires while the master keeps restarting it
  task automatic t_master;
    slave[6] = 1'b1;
    msel[6] = 3'h0;
    cfg(0, MODE_INTERVAL, 16'h0005, 1'b0);
    cfg(6, MODE_INTERVAL, 16'h0008, 1'b0);
    go(8'h41);
    repeat (40) tick();
    chk(16'(icnt[6]), 16'h0000);
    chk(16'(icnt[0] >= 6), 16'h0001);
    slave[6] = 1'b0;
    repeat (20) tick();
    chk(16'(icnt[6] > 0), 16'h0001);
    halt();
  endtask : t_master

  task automatic t_enable;
    cfg(2, MODE_INTERVAL, 16'h0003, 1'b0);
    go(8'h04);
    repeat (3) tick();
    en = 1'b0;
    tick();
    tick();
    chk(run[2], 1'b0);
    go(8'h04);
    en = 1'b1;
    repeat (10) tick();
    chk({run[2], 15'(icnt[2])}, 16'h0000);
  endtask : t_enable

  initial begin
    rst_n = 1'b0;
    en = 1'b1;
    lin_sel = 1'b0;
    {start, stop, split, fall, slave} = '0;
    mode = '0;
    msel = '0;
    per = '0;
    errors = 0;
    checks_done = 0;
    cycles = 0;
    clr();
    repeat (8) tick();
    rst_n = 1'b1;
    tick();
    t_interval();
    t_event_div();
    t_measure();
    t_delay();
    t_split();
    t_master();
    t_enable();
    end_sim();
  end
endmodule : tb_multi_channel_timer_unit
